/* File: hw/cfg_ident_pkg.sv */
// Package with the configuration, calibration and identity constants and types
package cfg_ident_pkg;
   localparam int unsigned ADDR_W         = 24;
   localparam int unsigned DATA_W         = 24;
   localparam int unsigned CAL_W          = 6;
   localparam int unsigned OTP_WORDS      = 32;
   localparam int unsigned OTP_IDX_W      = 5;
   localparam int unsigned OTP_IDX_LSB    = 2;
   localparam logic [23:0] AMP1_CAL_ADDR  = 24'h800e48;
   localparam logic [23:0] AMP2_CAL_ADDR  = 24'h800e4c;
   localparam logic [23:0] PART_ID_ADDR   = 24'h800f00;
   localparam logic [23:0] PART_REV_ADDR  = 24'h800f04;
   localparam logic [23:0] OTP_BASE_ADDR  = 24'h800f80;
   localparam logic [23:0] OTP_LAST_ADDR  = 24'h800ffc;
   localparam logic [23:0] OTP_ERASED     = 24'hffffff;
   localparam logic [23:0] UNMAPPED_DATA  = 24'h000000;
   // Window fraction in eighths of the watchdog period
   localparam logic [3:0]  WIN_EIGHTHS_11 = 4'h2;
   localparam logic [3:0]  WIN_EIGHTHS_10 = 4'h3;
   localparam logic [3:0]  WIN_EIGHTHS_01 = 4'h4;
   localparam logic [3:0]  WIN_EIGHTHS_00 = 4'h6;
   localparam logic [2:0]  PRIO_RESERVED  = 3'h7;
   localparam logic [2:0]  PRIO_NONE      = 3'h0;

   typedef struct packed {
      logic [1:0]        watchdog_window_select;
      logic              watchdog_window_disable;
      logic              test_port_enable;
      logic [1:0]        debug_channel_select;
      logic [2:0]        alt_set1_priority;
      logic [2:0]        alt_set2_priority;
      logic [CAL_W-1:0]  amp1_cal;
      logic [CAL_W-1:0]  amp2_cal;
      logic [DATA_W-1:0] part_identifier;
      logic [DATA_W-1:0] part_revision;
   } cfg_fields_t;

   typedef struct packed {
      logic       window_mode;
      logic [3:0] window_eighths;
      logic       test_port_on;
      logic [2:0] debug_pair_onehot;
      logic       debug_select_bad;
      logic [2:0] set1_level;
      logic [2:0] set2_level;
      logic       set1_reserved;
      logic       set2_reserved;
   } cfg_decoded_t;

   typedef struct packed {
      logic              rd;
      logic              wr;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } table_req_t;
endpackage

/* File: hw/device_config_and_identity.sv */
// Configuration decoder with table-read access to calibration, identity and one-time words
module device_config_and_identity
   import cfg_ident_pkg::*;
(
   input  wire logic              ref_clk_i,
   input  wire logic              rst_b_i,
   input  wire cfg_fields_t       cfg_fields_i,
   input  wire table_req_t        table_req_i,
   output logic                   cfg_valid_o,
   output cfg_decoded_t           cfg_decoded_o,
   output logic [DATA_W-1:0]      rd_data_o,
   output logic                   rd_valid_o,
   output logic                   wr_ignored_o
);

   // Which word a table address names; misaligned one-time addresses name nothing
   typedef enum logic [2:0] {SEL_NONE, SEL_AMP1, SEL_AMP2, SEL_ID, SEL_REV, SEL_OTP} table_sel_t;

   logic                 sampled_reg;
   cfg_fields_t          fields_reg;
   logic [DATA_W-1:0]    otp_mem [OTP_WORDS];
   logic [OTP_WORDS-1:0] otp_done_reg;
   logic [DATA_W-1:0]    rd_next;
   logic                 in_otp;
   logic [OTP_IDX_W-1:0] otp_idx;
   logic                 otp_write;
   logic                 load_decode;
   logic                 window_mode_reg;
   logic [3:0]           window_eighths_reg;
   logic                 test_port_on_reg;
   logic [2:0]           debug_pair_reg;
   logic                 debug_bad_reg;
   logic [2:0]           set1_level_reg;
   logic                 set1_reserved_reg;
   logic [2:0]           set2_level_reg;
   logic                 set2_reserved_reg;
   table_sel_t           rd_sel;

   function automatic logic [2:0] level_of(input logic [2:0] code);
      // Code plus one, reserved code gives no level
      if (code == PRIO_RESERVED) begin
         return PRIO_NONE;
      end
      return code + 3'h1;
   endfunction

   function automatic logic [3:0] window_of(input logic [1:0] sel);
      unique case (sel)
         2'h3: return WIN_EIGHTHS_11;
         2'h2: return WIN_EIGHTHS_10;
         2'h1: return WIN_EIGHTHS_01;
         2'h0: return WIN_EIGHTHS_00;
      endcase
   endfunction

   function automatic logic [2:0] pair_of(input logic [1:0] sel);
      // One-hot pin pair, the reserved code routes nowhere
      unique case (sel)
         2'h3: return 3'h1;
         2'h2: return 3'h2;
         2'h1: return 3'h4;
         2'h0: return 3'h0;
      endcase
   endfunction

   function automatic table_sel_t select_of(input logic [ADDR_W-1:0] addr);
      if (addr == AMP1_CAL_ADDR) begin
         return SEL_AMP1;
      end
      if (addr == AMP2_CAL_ADDR) begin
         return SEL_AMP2;
      end
      if (addr == PART_ID_ADDR) begin
         return SEL_ID;
      end
      if (addr == PART_REV_ADDR) begin
         return SEL_REV;
      end
      if ((addr >= OTP_BASE_ADDR) && (addr <= OTP_LAST_ADDR) && (addr[1:0] == 2'h0)) begin
         return SEL_OTP;
      end
      return SEL_NONE;
   endfunction

   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sampled_reg <= 1'b0;
         fields_reg  <= '0;
      end else if (!sampled_reg) begin
         sampled_reg <= 1'b1;
         fields_reg  <= cfg_fields_i;
      end
   end

   // Decoded fields load once, the cycle after capture, so they hold until the next reset
   assign load_decode = sampled_reg && !cfg_valid_o;

   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         cfg_valid_o <= 1'b0;
      end else if (load_decode) begin
         cfg_valid_o <= 1'b1;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         window_mode_reg <= 1'b0;
      end else if (load_decode) begin
         window_mode_reg <= ~fields_reg.watchdog_window_disable;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         window_eighths_reg <= 4'h0;
      end else if (load_decode) begin
         window_eighths_reg <= fields_reg.watchdog_window_disable ? 4'h0
                               : window_of(fields_reg.watchdog_window_select);
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         test_port_on_reg <= 1'b0;
      end else if (load_decode) begin
         test_port_on_reg <= fields_reg.test_port_enable;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         debug_pair_reg <= 3'h0;
         debug_bad_reg  <= 1'b0;
      end else if (load_decode) begin
         debug_pair_reg <= pair_of(fields_reg.debug_channel_select);
         debug_bad_reg  <= (fields_reg.debug_channel_select == 2'h0);
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         set1_level_reg    <= 3'h0;
         set1_reserved_reg <= 1'b0;
      end else if (load_decode) begin
         set1_level_reg    <= level_of(fields_reg.alt_set1_priority);
         set1_reserved_reg <= (fields_reg.alt_set1_priority == PRIO_RESERVED);
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         set2_level_reg    <= 3'h0;
         set2_reserved_reg <= 1'b0;
      end else if (load_decode) begin
         set2_level_reg    <= level_of(fields_reg.alt_set2_priority);
         set2_reserved_reg <= (fields_reg.alt_set2_priority == PRIO_RESERVED);
      end
   end

   // Outputs are the decode flip-flops themselves, only regrouped
   assign cfg_decoded_o = '{
      window_mode:       window_mode_reg,
      window_eighths:    window_eighths_reg,
      test_port_on:      test_port_on_reg,
      debug_pair_onehot: debug_pair_reg,
      debug_select_bad:  debug_bad_reg,
      set1_level:        set1_level_reg,
      set2_level:        set2_level_reg,
      set1_reserved:     set1_reserved_reg,
      set2_reserved:     set2_reserved_reg
   };

   assign rd_sel    = select_of(table_req_i.addr);
   assign in_otp    = (rd_sel == SEL_OTP);
   assign otp_idx   = table_req_i.addr[OTP_IDX_LSB +: OTP_IDX_W];
   // A used word is never rewritten, and a read in the same cycle takes precedence
   assign otp_write = table_req_i.wr && !table_req_i.rd && in_otp && !otp_done_reg[otp_idx];

   always_comb begin
      rd_next = UNMAPPED_DATA;
      unique case (rd_sel)
         SEL_AMP1: rd_next = {{(DATA_W-CAL_W){1'b0}}, fields_reg.amp1_cal};
         SEL_AMP2: rd_next = {{(DATA_W-CAL_W){1'b0}}, fields_reg.amp2_cal};
         SEL_ID:   rd_next = fields_reg.part_identifier;
         SEL_REV:  rd_next = fields_reg.part_revision;
         SEL_OTP:  rd_next = otp_done_reg[otp_idx] ? otp_mem[otp_idx] : OTP_ERASED;
         SEL_NONE: rd_next = UNMAPPED_DATA;
      endcase
   end

   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rd_data_o  <= '0;
         rd_valid_o <= 1'b0;
      end else begin
         rd_valid_o <= table_req_i.rd;
         if (table_req_i.rd) begin
            rd_data_o <= rd_next;
         end
      end
   end

   // A word is programmable once; the flag is what makes it non-rewritable
   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         otp_done_reg <= '0;
      end else if (otp_write) begin
         otp_done_reg[otp_idx] <= 1'b1;
      end
   end

   // Contents carry no reset: only the done flags decide what reads back
   always_ff @(posedge ref_clk_i) begin
      if (otp_write) begin
         otp_mem[otp_idx] <= table_req_i.wdata;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wr_ignored_o <= 1'b0;
      end else begin
         wr_ignored_o <= table_req_i.wr && !otp_write;
      end
   end

endmodule

/* File: test/dci_properties.sv */
// Checker of decode and table-access timing at the decoder ports
module dci_properties
   import cfg_ident_pkg::*;
(
   input  wire logic              ref_clk_i,
   input  wire logic              rst_b_i,
   input  wire cfg_fields_t       cfg_fields_i,
   input  wire table_req_t        table_req_i,
   input  wire logic              cfg_valid_o,
   input  wire cfg_decoded_t      cfg_decoded_o,
   input  wire logic [DATA_W-1:0] rd_data_o,
   input  wire logic              rd_valid_o,
   input  wire logic              wr_ignored_o
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!rst_b_i);
   wire table_req_t   q = table_req_i;
   wire cfg_decoded_t d = cfg_decoded_o;
   rd_answer_a: assert property (q.rd |=> rd_valid_o) // read answer
      else $error("read not answered");
   rd_quiet_a: assert property (!q.rd |=> !rd_valid_o) // no stray answer
      else $error("read answer without read");
   cfg_hold_a: assert property (cfg_valid_o |=> cfg_valid_o && $stable(d)) // held
      else $error("decoded fields moved");
   win_off_a: assert property (cfg_valid_o && !d.window_mode // window off
      |-> d.window_eighths == 4'h0)
      else $error("window size while disabled");
   dbg_route_a: assert property (cfg_valid_o // routing
      |-> $onehot0(d.debug_pair_onehot) && d.debug_select_bad == (d.debug_pair_onehot == 3'h0))
      else $error("debug routing inconsistent");
   set1_rsv_a: assert property (cfg_valid_o |-> d.set1_reserved == (d.set1_level == 3'h0))
      else $error("set 1 reserved flag wrong");
   set2_rsv_a: assert property (cfg_valid_o |-> d.set2_reserved == (d.set2_level == 3'h0))
      else $error("set 2 reserved flag wrong");
   cal_width_a: assert property (cfg_valid_o && q.rd && q.addr == AMP1_CAL_ADDR // cal width
      |=> rd_data_o[23:6] == 18'h0)
      else $error("calibration upper bits set");
   cal_write_a: assert property (q.wr && q.addr == AMP1_CAL_ADDR |=> wr_ignored_o)
      else $error("calibration write not refused");
   cover property ($rose(cfg_valid_o));
   cover property (wr_ignored_o);
   cover property (rd_valid_o && rd_data_o == OTP_ERASED);
endmodule

bind device_config_and_identity dci_properties u_props (.ref_clk_i, .rst_b_i, .cfg_fields_i,
   .table_req_i, .cfg_valid_o, .cfg_decoded_o, .rd_data_o, .rd_valid_o, .wr_ignored_o);

/* File: test/device_config_and_identity_test.sv */
// Self-checking bench for the configuration decoder and table access
module device_config_and_identity_test import cfg_ident_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic         ref_clk_i = 0;
   logic         rst_b_i = 0;
   cfg_fields_t  f = '0;
   table_req_t   q = '0;
   logic         cfg_valid_o, rd_valid_o, wr_ignored_o;
   cfg_decoded_t dec;
   logic [23:0]  rd_data_o;
   int           bad_count = 0;
   int           n_compared = 0;
   logic [31:0]  seed = 32'h00011ae0;
   always #10 ref_clk_i = ~ref_clk_i;
   device_config_and_identity dut (.ref_clk_i, .rst_b_i, .cfg_fields_i(f), .table_req_i(q),
      .cfg_valid_o, .cfg_decoded_o(dec), .rd_data_o, .rd_valid_o, .wr_ignored_o);
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic cfg_decoded_t exp_dec(cfg_fields_t c);
      cfg_decoded_t e;
      e = '0;
      e.window_mode = ~c.watchdog_window_disable;
      case (c.watchdog_window_select)
         2'h3: e.window_eighths = 4'h2;
         2'h2: e.window_eighths = 4'h3;
         2'h1: e.window_eighths = 4'h4;
         default: e.window_eighths = 4'h6;
      endcase
      if (!e.window_mode) e.window_eighths = 4'h0;
      e.test_port_on = c.test_port_enable;
      e.debug_pair_onehot = {c.debug_channel_select == 2'h1, c.debug_channel_select == 2'h2,
                             c.debug_channel_select == 2'h3};
      e.debug_select_bad = c.debug_channel_select == 2'h0;
      e.set1_reserved = &c.alt_set1_priority;
      e.set2_reserved = &c.alt_set2_priority;
      e.set1_level = e.set1_reserved ? 3'h0 : c.alt_set1_priority + 3'h1;
      e.set2_level = e.set2_reserved ? 3'h0 : c.alt_set2_priority + 3'h1;
      return e;
   endfunction
   task automatic cmp_w(string n, logic [23:0] e, logic [23:0] g);
      n_compared++;
      if (g !== e) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask
   // Request is held until replaced, so back-to-back calls stay one access per edge
   task automatic acc(logic r, logic w, logic [23:0] a, logic [23:0] d, logic [23:0] e, logic ig);
      q = '{r, w, a, d};
      @(posedge ref_clk_i);
      #1;
      if (r) cmp_w("rd_data", e, rd_data_o);
      cmp_w("flags", {r, ig}, {rd_valid_o, wr_ignored_o});
   endtask
   task automatic finish_test();
      if (bad_count == 0 && n_compared > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      cfg_fields_t g;
      logic [23:0] a, w;
      for (int k = 0; k < 8; k++) begin
         f = cfg_fields_t'(72'({rnd(), rnd(), rnd()}));
         f.watchdog_window_select = k[1:0];
         f.debug_channel_select = k[1:0];
         f.watchdog_window_disable = k[2];
         f.alt_set1_priority = k[2:0];
         f.alt_set2_priority = 3'(7 - k);
         g = f;
         rst_b_i = 0;
         repeat (10) @(posedge ref_clk_i);
         #1 rst_b_i = 1;
         cmp_w("reset", 24'h0, 24'({dec, cfg_valid_o, rd_valid_o, wr_ignored_o}));
         cmp_w("reset data", 24'h0, rd_data_o); // cleared
         repeat (2) @(posedge ref_clk_i);
         #1 f = ~f;
         cmp_w("valid", 24'h1, {23'h0, cfg_valid_o}); // ready
         cmp_w("decoded", 24'(exp_dec(g)), 24'(dec)); // map
         repeat (2) @(posedge ref_clk_i);
         #1 cmp_w("held", 24'(exp_dec(g)), 24'(dec)); // held
         acc(1, 0, AMP1_CAL_ADDR, 0, {18'h0, g.amp1_cal}, 0); // cal 1
         acc(1, 0, AMP2_CAL_ADDR, 0, {18'h0, g.amp2_cal}, 0); // cal 2
         acc(1, 0, PART_ID_ADDR, 0, g.part_identifier, 0); // identifier
         acc(1, 0, PART_REV_ADDR, 0, g.part_revision, 0); // revision
         acc(0, 1, AMP1_CAL_ADDR, 24'(rnd()), 0, 1); // write refused
         acc(1, 1, AMP1_CAL_ADDR, 24'(rnd()), {18'h0, g.amp1_cal}, 1); // read wins
         a = OTP_BASE_ADDR + 24'(4 * (k == 7 ? 31 : k));
         w = 24'(rnd());
         acc(1, 0, a, 0, OTP_ERASED, 0); // blank word
         acc(0, 1, a, w, 0, 0); // program
         acc(1, 0, a, 0, w, 0); // read back
         acc(0, 1, a, ~w, 0, 1); // second write
         acc(1, 0, a, 0, w, 0); // unchanged
         acc(1, 0, a + 24'h1, 0, UNMAPPED_DATA, 0); // misaligned
         q = '0;
      end
      finish_test();
   end
   initial begin
      #100us;
      bad_count++;
      finish_test();
   end
endmodule
